//--- imbs_consts.svh
// What this block does
// RULE_01 - Indexed jump: offset read, idle read at FFFF, fetch at jump address; 3 cycles.
// RULE_02 - Most classes read offset at opcode plus one, then idle read at FFFF.
// RULE_03 - Indexed 8-bit read: operand at index plus offset, next opcode at plus two; 4 cycles.
// RULE_04 - Accumulator store: write accumulator at index plus offset, then fetch; 4 cycles.
// RULE_05 - 16-bit load/compare/add: high byte then low byte read; 5 cycles.
// RULE_06 - 16-bit store: write high then low byte, read/write low; 5 cycles.
// RULE_07 - Call: push return low then high byte, fetch at index plus offset; 5 cycles.
// RULE_08 - Read-modify-write: read, idle FFFF, write new operand, fetch; 6 cycles.
// RULE_09 - Bit test: immediate, offset, idle, operand read, fetch at plus three; 5 cycles.
// RULE_10 - Clear: read operand, write location, fetch at plus two; 5 cycles.
// RULE_11 - Immediate logic to memory: imm, offset, idle, read, idle, write, fetch; 7 cycles.
// RULE_12 - Effective address is index plus zero-extended unsigned 8-bit offset.
//
// Purpose : Constants for the indexed-mode bus sequencer
// Assumes : Included by imbs_top.sv only
// Notes   : Definitions only
`ifndef IMBS_CONSTS_SVH
`define IMBS_CONSTS_SVH
`define IMBS_IDLE_ADDR 16'hFFFF
`define IMBS_ONE       16'h0001
`define IMBS_TWO       16'h0002
`define IMBS_THREE     16'h0003
`define IMBS_RESET_PC  16'h0000
`define IMBS_ZERO8     8'h00
`endif

//--- imbs_pkg.sv
// Purpose : Types for the indexed-mode bus sequencer
// Assumes : Nothing
// Notes   : Class codes are given by the decoder upstream
package imbs_pkg;
    typedef enum logic [3:0] {
        IMBS_JUMP, IMBS_READ8, IMBS_STORE8, IMBS_READ16, IMBS_STORE16,
        IMBS_CALL, IMBS_RMW, IMBS_TEST, IMBS_CLEAR, IMBS_LOGIC
    } imbs_class_t;
    typedef enum logic [1:0] {
        IMBS_NONE, IMBS_OPER, IMBS_OPER_LO, IMBS_IMM
    } imbs_cap_t;
endpackage

//--- imbs_top.sv
// Purpose : Drives address, read/write and data per machine cycle, indexed mode
// Assumes : Opcode already fetched; start pulses in the fetch cycle
// Notes   : New operand data and stored registers come from ports
`timescale 1ns/1ps
`default_nettype none
`include "imbs_consts.svh"
module imbs_top (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               clk_en,
    // Instruction start
    input  wire logic               start,
    input  wire imbs_pkg::imbs_class_t op_class,
    input  wire logic [15:0]        opcode_addr,
    input  wire logic [15:0]        index_reg,
    input  wire logic [15:0]        stack_ptr,
    // Data sources for writes
    input  wire logic [7:0]         acc_data,
    input  wire logic [15:0]        reg16_data,
    input  wire logic [7:0]         new_operand,
    // Bus
    input  wire logic [7:0]         data_in,
    output logic [15:0]             addr_bus,
    output logic                    rw_n,
    output logic [7:0]              data_out,
    output logic                    data_oe,
    // Status
    output logic                    busy,
    output logic                    fetch,
    output logic [7:0]              operand,
    output logic [7:0]              operand_lo,
    output logic [7:0]              imm_data
);
    // Sequencer state
    logic [2:0]              cyc_reg, cyc_next;
    imbs_pkg::imbs_class_t   cls_reg, cls_next;
    logic [15:0]             pc_reg, pc_next;
    logic [15:0]             ix_reg, ix_next;
    logic [15:0]             sp_reg, sp_next;
    logic [7:0]              off_reg, off_next;
    logic [15:0]             addr_reg, addr_next;
    logic                    rw_reg, rw_next;
    logic [7:0]              dout_reg, dout_next;
    logic                    oe_reg, oe_next;
    logic                    busy_reg, busy_next;
    logic                    fetch_reg, fetch_next;
    logic [7:0]              opr_reg, opr_next;
    logic [7:0]              oplo_reg, oplo_next;
    logic [7:0]              imm_reg, imm_next;
    imbs_pkg::imbs_cap_t     cap_reg, cap_next;
    logic [15:0]             eff;
    logic                    off_cap;

    // Effective address
    assign eff = ix_reg + {8'h00, off_reg}; // RULE_12

    // Offset captured from data_in during the offset cycle itself
    assign off_cap = busy_reg && ((cls_reg == imbs_pkg::IMBS_TEST || cls_reg == imbs_pkg::IMBS_LOGIC)
                                  ? (cyc_reg == 3'd2) : (cyc_reg == 3'd1));

    // Next-state logic
    always_comb begin
        cyc_next   = cyc_reg;
        cls_next   = cls_reg;
        pc_next    = pc_reg;
        ix_next    = ix_reg;
        sp_next    = sp_reg;
        off_next   = off_cap ? data_in : off_reg;
        addr_next  = addr_reg;
        rw_next    = 1'b1;
        dout_next  = `IMBS_ZERO8;
        oe_next    = 1'b0;
        busy_next  = busy_reg;
        fetch_next = 1'b0;
        opr_next   = (cap_reg == imbs_pkg::IMBS_OPER) ? data_in : opr_reg;
        oplo_next  = (cap_reg == imbs_pkg::IMBS_OPER_LO) ? data_in : oplo_reg;
        imm_next   = (cap_reg == imbs_pkg::IMBS_IMM) ? data_in : imm_reg;
        cap_next   = imbs_pkg::IMBS_NONE;
        if (!busy_reg) begin
            if (start) begin
                cls_next  = op_class;
                pc_next   = opcode_addr;
                ix_next   = index_reg;
                sp_next   = stack_ptr;
                busy_next = 1'b1;
                cyc_next  = 3'd1;
                addr_next = opcode_addr + `IMBS_ONE; // RULE_02
                if (op_class == imbs_pkg::IMBS_TEST || op_class == imbs_pkg::IMBS_LOGIC) begin
                    cap_next = imbs_pkg::IMBS_IMM; // RULE_09 RULE_11
                end
            end
        end else begin
            cyc_next = cyc_reg + 3'd1;
            unique case (cls_reg)
                imbs_pkg::IMBS_JUMP: begin // RULE_01
                    if (cyc_reg == 3'd1) begin
                        addr_next = `IMBS_IDLE_ADDR;
                    end else begin
                        addr_next = eff;
                        fetch_next = 1'b1;
                        busy_next = 1'b0;
                    end
                end
                imbs_pkg::IMBS_READ8, imbs_pkg::IMBS_STORE8: begin // RULE_03 RULE_04
                    unique case (cyc_reg)
                        3'd1: addr_next = `IMBS_IDLE_ADDR; // RULE_02
                        3'd2: begin
                            addr_next = eff;
                            if (cls_reg == imbs_pkg::IMBS_STORE8) begin
                                rw_next = 1'b0;
                                oe_next = 1'b1;
                                dout_next = acc_data;
                            end else begin
                                cap_next = imbs_pkg::IMBS_OPER;
                            end
                        end
                        default: begin
                            addr_next = pc_reg + `IMBS_TWO;
                            fetch_next = 1'b1;
                            busy_next = 1'b0;
                        end
                    endcase
                end
                imbs_pkg::IMBS_READ16, imbs_pkg::IMBS_STORE16: begin // RULE_05 RULE_06
                    unique case (cyc_reg)
                        3'd1: addr_next = `IMBS_IDLE_ADDR;
                        3'd2, 3'd3: begin
                            addr_next = (cyc_reg == 3'd2) ? eff : eff + `IMBS_ONE;
                            if (cls_reg == imbs_pkg::IMBS_STORE16) begin
                                rw_next = 1'b0;
                                oe_next = 1'b1;
                                dout_next = (cyc_reg == 3'd2) ? reg16_data[15:8] : reg16_data[7:0];
                            end else begin
                                cap_next = (cyc_reg == 3'd2) ? imbs_pkg::IMBS_OPER : imbs_pkg::IMBS_OPER_LO;
                            end
                        end
                        default: begin
                            addr_next = pc_reg + `IMBS_TWO;
                            fetch_next = 1'b1;
                            busy_next = 1'b0;
                        end
                    endcase
                end
                imbs_pkg::IMBS_CALL: begin // RULE_07
                    unique case (cyc_reg)
                        3'd1: addr_next = `IMBS_IDLE_ADDR;
                        3'd2, 3'd3: begin
                            addr_next = (cyc_reg == 3'd2) ? sp_reg : sp_reg - `IMBS_ONE;
                            rw_next = 1'b0;
                            oe_next = 1'b1;
                            dout_next = (cyc_reg == 3'd2) ? pc_next_ret_lo(pc_reg) : pc_next_ret_hi(pc_reg);
                        end
                        default: begin
                            addr_next = eff;
                            fetch_next = 1'b1;
                            busy_next = 1'b0;
                        end
                    endcase
                end
                imbs_pkg::IMBS_RMW, imbs_pkg::IMBS_CLEAR: begin // RULE_08 RULE_10
                    if (cyc_reg == 3'd1) begin
                        addr_next = `IMBS_IDLE_ADDR;
                    end else if (cyc_reg == 3'd2) begin
                        addr_next = eff;
                        cap_next = imbs_pkg::IMBS_OPER;
                    end else if (cyc_reg == 3'd3 && cls_reg == imbs_pkg::IMBS_RMW) begin
                        addr_next = `IMBS_IDLE_ADDR;
                    end else if ((cyc_reg == 3'd4 && cls_reg == imbs_pkg::IMBS_RMW) || cyc_reg == 3'd3) begin
                        addr_next = eff;
                        rw_next = 1'b0;
                        oe_next = 1'b1;
                        dout_next = (cls_reg == imbs_pkg::IMBS_CLEAR) ? `IMBS_ZERO8 : new_operand;
                    end else begin
                        addr_next = pc_reg + `IMBS_TWO;
                        fetch_next = 1'b1;
                        busy_next = 1'b0;
                    end
                end
                imbs_pkg::IMBS_TEST, imbs_pkg::IMBS_LOGIC: begin // RULE_09 RULE_11
                    if (cyc_reg == 3'd1) begin
                        addr_next = pc_reg + `IMBS_TWO;
                    end else if (cyc_reg == 3'd2) begin
                        addr_next = `IMBS_IDLE_ADDR;
                    end else if (cyc_reg == 3'd3) begin
                        addr_next = eff;
                        cap_next = imbs_pkg::IMBS_OPER;
                    end else if (cyc_reg == 3'd4 && cls_reg == imbs_pkg::IMBS_LOGIC) begin
                        addr_next = `IMBS_IDLE_ADDR;
                    end else if (cyc_reg == 3'd5) begin
                        addr_next = eff;
                        rw_next = 1'b0;
                        oe_next = 1'b1;
                        dout_next = new_operand;
                    end else begin
                        addr_next = pc_reg + `IMBS_THREE;
                        fetch_next = 1'b1;
                        busy_next = 1'b0;
                    end
                end
                default: begin
                    busy_next = 1'b0;
                end
            endcase
        end
    end

    // Return address is opcode plus two
    function automatic logic [7:0] pc_next_ret_lo(input logic [15:0] pc);
        logic [15:0] r;
        r = pc + `IMBS_TWO;
        return r[7:0];
    endfunction

    function automatic logic [7:0] pc_next_ret_hi(input logic [15:0] pc);
        logic [15:0] r;
        r = pc + `IMBS_TWO;
        return r[15:8];
    endfunction

    // State registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cyc_reg   <= 3'd0;
            cls_reg   <= imbs_pkg::IMBS_JUMP;
            pc_reg    <= `IMBS_RESET_PC;
            ix_reg    <= `IMBS_RESET_PC;
            sp_reg    <= `IMBS_RESET_PC;
            off_reg   <= `IMBS_ZERO8;
            addr_reg  <= `IMBS_IDLE_ADDR;
            rw_reg    <= 1'b1;
            dout_reg  <= `IMBS_ZERO8;
            oe_reg    <= 1'b0;
            busy_reg  <= 1'b0;
            fetch_reg <= 1'b0;
            opr_reg   <= `IMBS_ZERO8;
            oplo_reg  <= `IMBS_ZERO8;
            imm_reg   <= `IMBS_ZERO8;
            cap_reg   <= imbs_pkg::IMBS_NONE;
        end else if (clk_en) begin
            cyc_reg   <= cyc_next;
            cls_reg   <= cls_next;
            pc_reg    <= pc_next;
            ix_reg    <= ix_next;
            sp_reg    <= sp_next;
            off_reg   <= off_next;
            addr_reg  <= addr_next;
            rw_reg    <= rw_next;
            dout_reg  <= dout_next;
            oe_reg    <= oe_next;
            busy_reg  <= busy_next;
            fetch_reg <= fetch_next;
            opr_reg   <= opr_next;
            oplo_reg  <= oplo_next;
            imm_reg   <= imm_next;
            cap_reg   <= cap_next;
        end
    end

    // Outputs
    assign addr_bus   = addr_reg;
    assign rw_n       = rw_reg;
    assign data_out   = dout_reg;
    assign data_oe    = oe_reg;
    assign busy       = busy_reg;
    assign fetch      = fetch_reg;
    assign operand    = opr_reg;
    assign operand_lo = oplo_reg;
    assign imm_data   = imm_reg;
endmodule
`default_nettype wire

//--- imbs_mem_model.sv
// Purpose : Memory and peripherals seen on the indexed-mode bus
// Assumes : Reads answered in the same cycle
// Notes   : Byte at an address is a fixed mix of that address
`timescale 1ns/1ps
`default_nettype none
module imbs_mem_model (
    // Bus from the sequencer
    input  wire logic [15:0] addr_bus,
    input  wire logic        rw_n,
    input  wire logic [7:0]  data_out,
    // Read data back
    output logic [7:0]       data_in
);
    // Read pattern; inverted echo while the device drives the bus
    always_comb begin
        if (rw_n) begin
            data_in = addr_bus[7:0] ^ addr_bus[15:8] ^ 8'h5A;
        end else begin
            data_in = ~data_out;
        end
    end
endmodule
`default_nettype wire

//--- imbs_top_assertions.sv
// Purpose : Bus-cycle checks for imbs_top
// Assumes : A clock-enable gap cancels open checks
// Notes   : Bound to every imbs_top
`timescale 1ns/1ps
`default_nettype none
module imbs_top_checker (
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic                  clk_en,
    // Instruction start
    input wire logic                  start,
    input wire imbs_pkg::imbs_class_t op_class,
    input wire logic [15:0]           opcode_addr,
    input wire logic [15:0]           index_reg,
    input wire logic [15:0]           stack_ptr,
    input wire logic [7:0]            acc_data,
    // Bus and status
    input wire logic [7:0]            data_in,
    input wire logic [15:0]           addr_bus,
    input wire logic                  rw_n,
    input wire logic [7:0]            data_out,
    input wire logic                  data_oe,
    input wire logic                  busy,
    input wire logic                  fetch
);
    // ----
    // Cycle checks
    // ----
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !clk_en);
    wire logic tk;
    assign tk = start && !busy;
    a_offset_idle: assert property (tk && !(op_class inside {imbs_pkg::IMBS_TEST, imbs_pkg::IMBS_LOGIC})
        |=> addr_bus == $past(opcode_addr) + 16'h0001 && rw_n ##1 addr_bus == 16'hFFFF && rw_n)
        else $error("offset or idle cycle wrong");
    a_jump_target: assert property (tk && op_class == imbs_pkg::IMBS_JUMP |=> busy ##1 busy
        ##1 fetch && !busy && addr_bus == $past(index_reg, 3) + {8'h00, $past(data_in, 2)})
        else $error("jump target cycle wrong");
    a_read_fetch: assert property (tk && op_class == imbs_pkg::IMBS_READ8 |=> busy[*3]
        ##1 fetch && addr_bus == $past(opcode_addr, 4) + 16'h0002) else $error("read fetch wrong");
    a_store_acc: assert property (tk && op_class == imbs_pkg::IMBS_STORE8 |=> ##2 !rw_n && data_oe
        && data_out == $past(acc_data) ##1 rw_n && !data_oe && fetch) else $error("store cycle wrong");
    a_load_pair: assert property (tk && op_class == imbs_pkg::IMBS_READ16 |=> ##2 rw_n
        && addr_bus == $past(index_reg, 3) + {8'h00, $past(data_in, 2)}
        ##1 rw_n && addr_bus == $past(addr_bus) + 16'h0001 ##1 fetch) else $error("pair read wrong");
    a_store_pair: assert property (tk && op_class == imbs_pkg::IMBS_STORE16 |=> ##2 (!rw_n && data_oe)[*2]
        ##1 rw_n && fetch) else $error("pair write wrong");
    a_call_push: assert property (tk && op_class == imbs_pkg::IMBS_CALL |=> ##2 !rw_n
        && addr_bus == $past(stack_ptr, 3) ##1 !rw_n && addr_bus == $past(stack_ptr, 4) - 16'h0001
        ##1 fetch) else $error("call push wrong");
    a_rmw_order: assert property (tk && op_class == imbs_pkg::IMBS_RMW |=> ##2 rw_n
        ##1 rw_n && addr_bus == 16'hFFFF ##1 !rw_n ##1 fetch) else $error("modify order wrong");
    a_test_order: assert property (tk && op_class == imbs_pkg::IMBS_TEST
        |=> addr_bus == $past(opcode_addr) + 16'h0001 ##1 addr_bus == $past(addr_bus) + 16'h0001
        ##1 addr_bus == 16'hFFFF ##2 fetch && addr_bus == $past(opcode_addr, 5) + 16'h0003)
        else $error("bit test order wrong");
    a_clear_zero: assert property (tk && op_class == imbs_pkg::IMBS_CLEAR |=> ##3 !rw_n
        && data_out == 8'h00 && addr_bus == $past(addr_bus) ##1 fetch) else $error("clear wrong");
    a_logic_order: assert property (tk && op_class == imbs_pkg::IMBS_LOGIC |=> ##2 addr_bus == 16'hFFFF
        ##1 rw_n ##1 addr_bus == 16'hFFFF ##1 !rw_n ##1 rw_n && fetch) else $error("logic order wrong");
    // Main scenarios
    cover property (tk && op_class == imbs_pkg::IMBS_LOGIC);
    cover property (tk && fetch);
    cover property (start && busy);
endmodule
bind imbs_top imbs_top_checker i_chk (.*);
`default_nettype wire

//--- tb_top.sv
// Purpose : Self-checking bench for imbs_top
// Assumes : Memory model answers every read at once
// Notes   : Table rows run back to back
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {imbs_pkg::imbs_class_t c; logic [15:0] op, ix, sp; int n;} imbs_row_t;
    logic                  clock = 1'h0, rst = 1'h1, clk_en = 1'h1, start = 1'h0, rw_n, data_oe, busy, fetch;
    imbs_pkg::imbs_class_t op_class = imbs_pkg::IMBS_JUMP;
    logic [15:0]           opcode_addr = 16'h0000, index_reg = 16'h0000, stack_ptr = 16'h0000;
    logic [15:0]           reg16_data = 16'h0000, addr_bus, eff, ea[$];
    logic [7:0]            acc_data = 8'h00, new_operand = 8'h00, data_in, data_out;
    logic [7:0]            operand, operand_lo, imm_data, ed[$];
    logic                  er[$];
    int                    failures = 0, compares = 0, cycles = 0;
    imbs_row_t rows[11] = '{'{imbs_pkg::IMBS_JUMP, 16'h1000, 16'h2000, 16'h0100, 3},
        '{imbs_pkg::IMBS_READ8, 16'h1100, 16'h2100, 16'h0100, 4},
        '{imbs_pkg::IMBS_STORE8, 16'h1200, 16'h2200, 16'h0100, 4},
        '{imbs_pkg::IMBS_READ16, 16'h1300, 16'h2300, 16'h0100, 5},
        '{imbs_pkg::IMBS_STORE16, 16'h1400, 16'h2400, 16'h0100, 5},
        '{imbs_pkg::IMBS_CALL, 16'h1500, 16'h2500, 16'h01F0, 5},
        '{imbs_pkg::IMBS_RMW, 16'h1600, 16'h2600, 16'h0100, 6},
        '{imbs_pkg::IMBS_TEST, 16'h1700, 16'h2700, 16'h0100, 5},
        '{imbs_pkg::IMBS_CLEAR, 16'h1800, 16'h2800, 16'h0100, 5},
        '{imbs_pkg::IMBS_LOGIC, 16'h1900, 16'h2900, 16'h0100, 7},
        '{imbs_pkg::IMBS_READ16, 16'h3000, 16'hFFF0, 16'h0100, 5}};
    // ----
    // Design, memory and clock
    // ----
    imbs_top i_dut (.clock(clock), .rst(rst), .clk_en(clk_en), .start(start), .op_class(op_class),
        .opcode_addr(opcode_addr), .index_reg(index_reg), .stack_ptr(stack_ptr), .acc_data(acc_data),
        .reg16_data(reg16_data), .new_operand(new_operand), .data_in(data_in), .addr_bus(addr_bus),
        .rw_n(rw_n), .data_out(data_out), .data_oe(data_oe), .busy(busy), .fetch(fetch),
        .operand(operand), .operand_lo(operand_lo), .imm_data(imm_data));
    imbs_mem_model i_mem (.addr_bus(addr_bus), .rw_n(rw_n), .data_out(data_out), .data_in(data_in));
    always #10 clock = ~clock;
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            summarize();
        end
    end
    function automatic logic [7:0] mem(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic p(input logic [15:0] a, input logic r = 1'h1, input logic [7:0] d = 8'h00);
        ea.push_back(a);
        er.push_back(r);
        ed.push_back(d);
    endtask
    task automatic apply(input imbs_row_t w);
        start = 1'h1;
        op_class = w.c;
        opcode_addr = w.op;
        index_reg = w.ix;
        stack_ptr = w.sp;
        acc_data = w.op[15:8];
        reg16_data = ~w.ix;
        new_operand = w.ix[15:8];
    endtask
    // Expected address, direction and write data per cycle
    task automatic build(input imbs_row_t w);
        logic two, o2;
        logic [15:0] ret;
        two = w.c inside {imbs_pkg::IMBS_TEST, imbs_pkg::IMBS_LOGIC};
        eff = w.ix + {8'h00, mem(w.op + (two ? 16'h0002 : 16'h0001))};
        ret = w.op + 16'h0002;
        ea = {};
        er = {};
        ed = {};
        p(w.op + 16'h0001);
        p(two ? ret : 16'hFFFF);
        if (two) p(16'hFFFF);
        if (w.c != imbs_pkg::IMBS_CALL) p(eff, w.c != imbs_pkg::IMBS_STORE8 && w.c != imbs_pkg::IMBS_STORE16,
            w.c == imbs_pkg::IMBS_STORE8 ? acc_data : reg16_data[15:8]);
        case (w.c)
            imbs_pkg::IMBS_READ16: p(eff + 16'h0001);
            imbs_pkg::IMBS_STORE16: p(eff + 16'h0001, 1'h0, reg16_data[7:0]);
            imbs_pkg::IMBS_CALL: begin
                p(w.sp, 1'h0, ret[7:0]);
                p(w.sp - 16'h0001, 1'h0, ret[15:8]);
                p(eff);
            end
            imbs_pkg::IMBS_RMW, imbs_pkg::IMBS_LOGIC: begin
                p(16'hFFFF);
                p(eff, 1'h0, new_operand);
            end
            imbs_pkg::IMBS_CLEAR: p(eff, 1'h0, 8'h00);
            default: ;
        endcase
        o2 = w.c inside {imbs_pkg::IMBS_JUMP, imbs_pkg::IMBS_CALL};
        if (!o2) p(two ? w.op + 16'h0003 : ret);
    endtask
    // One instruction; mode 1 pokes start while busy, mode 2 stalls clk_en
    task automatic run(input imbs_row_t w, input int nx, input int mode);
        for (int k = 0; k < w.n; k++) begin
            @(negedge clock);
            start = (mode == 1 && k == 1);
            chk(addr_bus, ea[k]);
            chk(rw_n, er[k]);
            if (!er[k]) chk(data_out, ed[k]);
            chk(data_oe, !er[k]);
            chk(fetch, k == w.n - 1);
            chk(busy, k < w.n - 1);
            if (k == w.n - 1 && !(w.c inside {imbs_pkg::IMBS_JUMP, imbs_pkg::IMBS_STORE8,
                                              imbs_pkg::IMBS_STORE16, imbs_pkg::IMBS_CALL}))
                chk(operand, mem(eff));
            if (k == w.n - 1 && w.c == imbs_pkg::IMBS_READ16) chk(operand_lo, mem(eff + 16'h0001));
            if (k == w.n - 1 && w.c == imbs_pkg::IMBS_TEST) chk(imm_data, mem(w.op + 16'h0001));
            if (mode == 2 && k == 1) begin
                clk_en = 1'h0;
                repeat (2) @(negedge clock);
                chk(addr_bus, ea[k]);
                clk_en = 1'h1;
            end
            if (k == w.n - 1 && nx >= 0) apply(rows[nx]);
        end
    endtask
    task automatic rchk;
        chk(addr_bus, 16'hFFFF);
        chk({data_oe, busy, fetch, rw_n, operand}, 16'h0100);
    endtask
    task automatic summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Reset, table pass, then refused start, stall and mid-run reset
    initial begin
        repeat (6) @(negedge clock);
        rchk();
        rst = 1'h0;
        apply(rows[0]);
        for (int r = 0; r < 11; r++) begin
            build(rows[r]);
            run(rows[r], r < 10 ? r + 1 : -1, 0);
        end
        @(negedge clock);
        apply(rows[0]);
        build(rows[0]);
        run(rows[0], 6, 1);
        build(rows[6]);
        run(rows[6], -1, 2);
        @(negedge clock);
        apply(rows[9]);
        @(negedge clock);
        start = 1'h0;
        rst = 1'h1;
        @(negedge clock);
        rchk();
        rst = 1'h0;
        apply(rows[9]);
        build(rows[9]);
        run(rows[9], -1, 0);
        summarize();
    end
endmodule
`default_nettype wire
